/* clock_switch_pkg.sv */
`default_nettype none

package clock_switch_pkg;

  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;

  // Register offsets on the plain register port.
  localparam logic [ADDR_W-1:0] OFS_OSC_RUN      = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_CLK_SEL      = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_LOW_SEL      = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_OSC_MODE     = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_SETTLE_SEL   = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_SETTLE_STAT  = 3'h5;

  // Field positions of oscillator_run_control.
  localparam int unsigned RUN_MAIN_HALT_BIT = 7;
  localparam int unsigned RUN_SUB_HALT_BIT  = 6;
  localparam int unsigned RUN_MID_EN_BIT    = 1;
  localparam int unsigned RUN_HIGH_HALT_BIT = 0;

  // Field positions of clock_source_select.
  localparam int unsigned SEL_CPU_STAT_BIT    = 7;
  localparam int unsigned SEL_CPU_SRC_BIT     = 6;
  localparam int unsigned SEL_MAIN_STAT_BIT   = 5;
  localparam int unsigned SEL_MAIN_SRC_BIT    = 4;
  localparam int unsigned SEL_ONCHIP_STAT_BIT = 1;
  localparam int unsigned SEL_ONCHIP_SRC_BIT  = 0;

  // Field positions of low_speed_osc_select and oscillator_mode_config.
  localparam int unsigned LOW_RUN_BIT   = 0;
  localparam int unsigned MODE_EXT_BIT  = 7;
  localparam int unsigned MODE_XTAL_BIT = 6;
  localparam int unsigned MODE_GAIN_BIT = 0;

  // Reset values.
  localparam logic [DATA_W-1:0] OSC_RUN_RESET    = 8'hc0;
  localparam logic [DATA_W-1:0] CLK_SEL_RESET    = 8'h00;
  localparam logic [DATA_W-1:0] LOW_SEL_RESET    = 8'h00;
  localparam logic [DATA_W-1:0] OSC_MODE_RESET   = 8'h00;
  localparam logic [DATA_W-1:0] SETTLE_SEL_RESET = 8'h07;

  // Writable bits of each register; the others read as stored constants or status.
  localparam logic [DATA_W-1:0] OSC_RUN_WMASK    = 8'hc3;
  localparam logic [DATA_W-1:0] CLK_SEL_WMASK    = 8'h51;
  localparam logic [DATA_W-1:0] LOW_SEL_WMASK    = 8'h01;
  localparam logic [DATA_W-1:0] OSC_MODE_WMASK   = 8'hc1;
  localparam logic [DATA_W-1:0] SETTLE_SEL_WMASK = 8'h07;

  // Crystal settle counter: eight stages, counted in crystal periods.
  localparam int unsigned SETTLE_SEL_W  = 3;
  localparam int unsigned SETTLE_STAGES = 8;
  localparam int unsigned SETTLE_CNT_W  = 19;
  localparam logic [SETTLE_CNT_W-1:0] SETTLE_ONE = 19'h00001;

  typedef enum logic [2:0] {
    SW_RUN   = 3'b001,
    SW_DRAIN = 3'b010,
    SW_FILL  = 3'b100
  } sw_state_t;

  // Power of two, in crystal periods, at which settle stage idx completes.
  function automatic int unsigned settle_exp(input logic [SETTLE_SEL_W-1:0] idx);
    case (idx)
      3'h0:    settle_exp = 8;
      3'h1:    settle_exp = 9;
      3'h2:    settle_exp = 10;
      3'h3:    settle_exp = 11;
      3'h4:    settle_exp = 13;
      3'h5:    settle_exp = 15;
      3'h6:    settle_exp = 17;
      default: settle_exp = 18;
    endcase
  endfunction

  // Merges written data into a register through its writable-bit mask.
  function automatic logic [DATA_W-1:0] masked_write(input logic [DATA_W-1:0] old_v,
                                                     input logic [DATA_W-1:0] new_v,
                                                     input logic [DATA_W-1:0] mask);
    masked_write = (old_v & ~mask) | (new_v & mask);
  endfunction

endpackage

`default_nettype wire

/* clock_glitch_free_switch.sv */
`default_nettype none

module clock_glitch_free_switch
  import clock_switch_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic sel,
  input  wire logic tick_a,
  input  wire logic tick_b,
  output logic      tick_out,
  output logic      active
);

  sw_state_t state_q;
  logic      active_q;
  logic      target_q;
  logic      old_tick;
  logic      new_tick;

  assign old_tick = active_q ? tick_b : tick_a;
  assign new_tick = target_q ? tick_b : tick_a;

  // The old source finishes its period, the output rests, then the new one takes over.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= SW_RUN;
    end else begin
      case (state_q)
        SW_RUN: begin
          if (sel != active_q) begin
            state_q <= SW_DRAIN;
          end
        end
        SW_DRAIN: begin
          if (old_tick) begin
            state_q <= SW_FILL;
          end
        end
        SW_FILL: begin
          if (new_tick) begin
            state_q <= SW_RUN;
          end
        end
        default: state_q <= SW_RUN;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      target_q <= 1'b0;
    end else if (state_q == SW_RUN && sel != active_q) begin
      target_q <= sel;
    end
  end

  // The reported source changes only once the new source has produced an edge.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      active_q <= 1'b0;
    end else if (state_q == SW_FILL && new_tick) begin
      active_q <= target_q;
    end
  end

  assign tick_out = (state_q == SW_RUN) && old_tick;
  assign active   = active_q;

endmodule

`default_nettype wire

/* cpu_clock_source_switcher.sv */
`default_nettype none

module cpu_clock_source_switcher
  import clock_switch_pkg::*;
#(
  parameter logic [SETTLE_CNT_W-1:0] SETTLE_STEP = SETTLE_ONE
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [DATA_W-1:0] rdata,
  input  wire logic              high_osc_tick,
  input  wire logic              mid_osc_tick,
  input  wire logic              low_osc_tick,
  input  wire logic              main_crystal_tick,
  output logic                   high_speed_osc_run,
  output logic                   mid_speed_osc_run,
  output logic                   low_speed_osc_run,
  output logic                   crystal_amp_en,
  output logic                   ext_clock_in_en,
  output logic                   high_freq_gain,
  output logic                   cpu_peripheral_clock_tick
);

  logic [DATA_W-1:0]       osc_run_q;
  logic [DATA_W-1:0]       clk_sel_q;
  logic [DATA_W-1:0]       low_sel_q;
  logic [DATA_W-1:0]       osc_mode_q;
  logic [DATA_W-1:0]       settle_sel_q;
  logic [DATA_W-1:0]       rdata_q;
  logic [DATA_W-1:0]       rdata_d;
  logic [SETTLE_CNT_W-1:0] settle_cnt_q;
  logic [SETTLE_STAGES-1:0] settle_stat_q;
  logic [SETTLE_STAGES-1:0] settle_stat_d;
  logic                    crystal_mode;
  logic                    ext_mode;
  logic                    main_halted;
  logic                    settle_done;
  logic                    high_sys_tick;
  logic                    onchip_tick;
  logic                    main_sys_tick;
  logic                    onchip_active;
  logic                    main_active;
  logic                    cpu_active;
  logic                    wr_run;
  logic                    wr_sel;
  logic                    wr_low;
  logic                    wr_mode;
  logic                    wr_settle;

  assign wr_run    = wr_en && addr == OFS_OSC_RUN;
  assign wr_sel    = wr_en && addr == OFS_CLK_SEL;
  assign wr_low    = wr_en && addr == OFS_LOW_SEL;
  assign wr_mode   = wr_en && addr == OFS_OSC_MODE;
  assign wr_settle = wr_en && addr == OFS_SETTLE_SEL;

  // Oscillator run control register.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      osc_run_q <= OSC_RUN_RESET;
    end else if (wr_run) begin
      osc_run_q <= masked_write(osc_run_q, wdata, OSC_RUN_WMASK);
    end
  end

  // Clock source select register; only the select bits are stored.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clk_sel_q <= CLK_SEL_RESET;
    end else if (wr_sel) begin
      clk_sel_q <= masked_write(clk_sel_q, wdata, CLK_SEL_WMASK);
    end
  end

  // Low-speed oscillator select register.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      low_sel_q <= LOW_SEL_RESET;
    end else if (wr_low) begin
      low_sel_q <= masked_write(low_sel_q, wdata, LOW_SEL_WMASK);
    end
  end

  // Oscillator mode register.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      osc_mode_q <= OSC_MODE_RESET;
    end else if (wr_mode) begin
      osc_mode_q <= masked_write(osc_mode_q, wdata, OSC_MODE_WMASK);
    end
  end

  // Crystal settle time select register.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      settle_sel_q <= SETTLE_SEL_RESET;
    end else if (wr_settle) begin
      settle_sel_q <= masked_write(settle_sel_q, wdata, SETTLE_SEL_WMASK);
    end
  end

  // Oscillator controls driven straight from the stored bits.
  assign mid_speed_osc_run  = osc_run_q[RUN_MID_EN_BIT];
  assign high_speed_osc_run = ~osc_run_q[RUN_HIGH_HALT_BIT];
  assign low_speed_osc_run  = low_sel_q[LOW_RUN_BIT];
  assign high_freq_gain     = osc_mode_q[MODE_GAIN_BIT];

  assign crystal_mode = osc_mode_q[MODE_XTAL_BIT];
  assign ext_mode     = osc_mode_q[MODE_EXT_BIT];
  assign main_halted  = osc_run_q[RUN_MAIN_HALT_BIT];

  // The amplifier runs only in crystal mode; with both bits set the pin takes a clock.
  assign crystal_amp_en  = crystal_mode && !ext_mode && !main_halted;
  assign ext_clock_in_en = crystal_mode && ext_mode && !main_halted;

  // Settle counter counts crystal periods from the start; a halt clears it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      settle_cnt_q <= '0;
    end else if (!crystal_amp_en) begin
      settle_cnt_q <= '0;
    end else if (main_crystal_tick && !settle_stat_q[0]) begin
      settle_cnt_q <= settle_cnt_q + SETTLE_STEP;
    end
  end

  // Stage i completes at two to the power settle_exp(i); bit 7 is the first stage.
  always_comb begin
    settle_stat_d = '0;
    for (int i = 0; i < SETTLE_STAGES; i++) begin
      if (settle_cnt_q >= (SETTLE_ONE << settle_exp(SETTLE_SEL_W'(i)))) begin
        settle_stat_d[SETTLE_STAGES-1-i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      settle_stat_q <= '0;
    end else if (!crystal_amp_en) begin
      settle_stat_q <= '0;
    end else begin
      settle_stat_q <= settle_stat_d;
    end
  end

  // Code k releases the crystal once stage k of the status has filled.
  assign settle_done = settle_stat_q[SETTLE_STAGES-1-settle_sel_q[SETTLE_SEL_W-1:0]];

  // The external clock bypasses the settle wait entirely.
  assign high_sys_tick = main_crystal_tick &&
                         ((ext_clock_in_en) || (crystal_amp_en && settle_done));

  // On-chip clock: 0 high-speed, 1 middle-speed oscillator.
  clock_glitch_free_switch u_onchip_switch (
    .clk      (clk),
    .rst_n    (rst_n),
    .sel      (clk_sel_q[SEL_ONCHIP_SRC_BIT]),
    .tick_a   (high_osc_tick && high_speed_osc_run),
    .tick_b   (mid_osc_tick && mid_speed_osc_run),
    .tick_out (onchip_tick),
    .active   (onchip_active)
  );

  // Main system clock: 0 on-chip oscillator clock, 1 high-speed system clock.
  clock_glitch_free_switch u_main_switch (
    .clk      (clk),
    .rst_n    (rst_n),
    .sel      (clk_sel_q[SEL_MAIN_SRC_BIT]),
    .tick_a   (onchip_tick),
    .tick_b   (high_sys_tick),
    .tick_out (main_sys_tick),
    .active   (main_active)
  );

  // CPU and peripheral clock: 0 main system clock, 1 subsystem clock.
  clock_glitch_free_switch u_cpu_switch (
    .clk      (clk),
    .rst_n    (rst_n),
    .sel      (clk_sel_q[SEL_CPU_SRC_BIT]),
    .tick_a   (main_sys_tick),
    .tick_b   (low_osc_tick && low_speed_osc_run),
    .tick_out (cpu_peripheral_clock_tick),
    .active   (cpu_active)
  );

  // Read mux; status bits show the source that is really driving each stage.
  always_comb begin
    rdata_d = '0;
    case (addr)
      OFS_OSC_RUN:    rdata_d = osc_run_q;
      OFS_CLK_SEL: begin
        rdata_d = clk_sel_q;
        rdata_d[SEL_CPU_STAT_BIT]    = cpu_active;
        rdata_d[SEL_MAIN_STAT_BIT]   = main_active;
        rdata_d[SEL_ONCHIP_STAT_BIT] = onchip_active;
      end
      OFS_LOW_SEL:     rdata_d = low_sel_q;
      OFS_OSC_MODE:    rdata_d = osc_mode_q;
      OFS_SETTLE_SEL:  rdata_d = settle_sel_q;
      OFS_SETTLE_STAT: rdata_d = settle_stat_q;
      default:         rdata_d = '0;
    endcase
  end

  // Read data stand for the one cycle after the read strobe, zero otherwise.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (rd_en) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= '0;
    end
  end

  assign rdata = rdata_q;

endmodule

`default_nettype wire

/* clock_switch_chk.sv */
`default_nettype none

module clock_switch_chk
  import clock_switch_pkg::*;
#(
  parameter logic [SETTLE_CNT_W-1:0] SETTLE_STEP = SETTLE_ONE
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              wr_en,
  input wire logic              rd_en,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic              high_osc_tick,
  input wire logic              mid_osc_tick,
  input wire logic              low_osc_tick,
  input wire logic              main_crystal_tick,
  input wire logic              high_speed_osc_run,
  input wire logic              mid_speed_osc_run,
  input wire logic              low_speed_osc_run,
  input wire logic              crystal_amp_en,
  input wire logic              ext_clock_in_en,
  input wire logic              high_freq_gain,
  input wire logic              cpu_peripheral_clock_tick
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  mid_run_a: assert property (wr_en && addr == OFS_OSC_RUN |=>
    mid_speed_osc_run == $past(wdata[RUN_MID_EN_BIT])) else $error("mid run wrong");
  high_run_a: assert property (wr_en && addr == OFS_OSC_RUN |=>
    high_speed_osc_run != $past(wdata[RUN_HIGH_HALT_BIT])) else $error("high run wrong");
  low_run_a: assert property (wr_en && addr == OFS_LOW_SEL |=>
    low_speed_osc_run == $past(wdata[LOW_RUN_BIT])) else $error("low run wrong");
  xtal_halt_a: assert property (wr_en && addr == OFS_OSC_RUN && wdata[RUN_MAIN_HALT_BIT] |=>
    !crystal_amp_en && !ext_clock_in_en) else $error("crystal not halted");
  mode_excl_a: assert property (!(crystal_amp_en && ext_clock_in_en))
    else $error("crystal and external both on");
  ext_no_amp_a: assert property (wr_en && addr == OFS_OSC_MODE && wdata[MODE_EXT_BIT] |=>
    !crystal_amp_en) else $error("crystal amplifier on with external clock");
  settle_fill_a: assert property ($past(rd_en && addr == OFS_SETTLE_STAT) |->
    ((~rdata) & ((~rdata) + 8'h01)) == 8'h00) else $error("settle status not filled from top");
  tick_source_a: assert property (cpu_peripheral_clock_tick |->
    high_osc_tick || mid_osc_tick || low_osc_tick || main_crystal_tick)
    else $error("cpu tick without source tick");
  low_gate_a: assert property (cpu_peripheral_clock_tick && !high_osc_tick && !mid_osc_tick
    && !main_crystal_tick |-> low_speed_osc_run) else $error("stopped low source passed");
endmodule

bind cpu_clock_source_switcher clock_switch_chk #(.SETTLE_STEP(SETTLE_STEP)) u_chk (.*);

`default_nettype wire

/* cpu_clock_source_switcher_tb_top.sv */
`default_nettype none

module cpu_clock_source_switcher_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import clock_switch_pkg::*;
  logic              clk;
  logic              rst_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr_en;
  logic              rd_en;
  logic [DATA_W-1:0] rdata;
  logic              high_osc_tick;
  logic              mid_osc_tick;
  logic              low_osc_tick;
  logic              main_crystal_tick;
  logic              high_speed_osc_run;
  logic              mid_speed_osc_run;
  logic              low_speed_osc_run;
  logic              crystal_amp_en;
  logic              ext_clock_in_en;
  logic              high_freq_gain;
  logic              cpu_peripheral_clock_tick;
  logic [7:0]        d;
  logic              ext_on;
  int                cnt;
  int                n_mismatch;
  int                samples_checked;
  logic [7:0]        rv [8] = '{8'hc0, 8'h00, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00};

  cpu_clock_source_switcher #(.SETTLE_STEP(19'h00100)) dut (.*);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Each source ticks only while its oscillator is running.
  always @(posedge clk) begin
    cnt <= cnt + 1;
    high_osc_tick <= high_speed_osc_run && (cnt % 3 == 0);
    mid_osc_tick <= mid_speed_osc_run && (cnt % 5 == 0);
    low_osc_tick <= low_speed_osc_run && (cnt % 7 == 0);
    main_crystal_tick <= (crystal_amp_en || ext_on) && (cnt % 2 == 0);
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 v = rdata;
    @(posedge clk);
  endtask

  task automatic poll(input logic [ADDR_W-1:0] a, input int b, input logic val,
                      output logic [DATA_W-1:0] v);
    for (int i = 0; i < 300; i++) begin
      rd(a, v);
      if (v[b] === val) return;
    end
    n_mismatch++;
    $display("wrong value poll timeout expected %h seen %h", val, v[b]);
    report_and_stop();
  endtask

  // Compares the CPU tick with one source tick over forty cycles.
  task automatic follow(input int src, input string name);
    int   bad;
    logic e;
    bad = 0;
    repeat (40) begin
      @(negedge clk);
      e = (src == 0) ? high_osc_tick : (src == 1) ? mid_osc_tick :
          (src == 2) ? low_osc_tick : main_crystal_tick;
      if (cpu_peripheral_clock_tick !== e) bad++;
    end
    chk(name, 8'h00, bad[7:0]);
    @(posedge clk);
  endtask

  initial begin
    {rst_n, addr, wdata, wr_en, rd_en, ext_on, n_mismatch, samples_checked} = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      rd(i[2:0], d);
      chk("reset read", rv[i], d);
    end
    follow(0, "on high");
    wr(OFS_OSC_RUN, 8'hfe);
    rd(OFS_OSC_RUN, d);
    chk("run reg", 8'hc2, d);
    chk("runs", 8'h03, {6'h0, high_speed_osc_run, mid_speed_osc_run});
    repeat (400) @(posedge clk);
    wr(OFS_CLK_SEL, 8'h01);
    poll(OFS_CLK_SEL, SEL_ONCHIP_STAT_BIT, 1'b1, d);
    chk("sel mid", 8'h03, d);
    follow(1, "on mid");
    wr(OFS_OSC_RUN, 8'hc3);
    chk("high run", 8'h00, {7'h0, high_speed_osc_run});
    wr(OFS_LOW_SEL, 8'hff);
    rd(OFS_LOW_SEL, d);
    chk("low reg", 8'h01, d);
    wr(OFS_CLK_SEL, 8'hc1);
    poll(OFS_CLK_SEL, SEL_CPU_STAT_BIT, 1'b1, d);
    chk("sel sub", 8'hc3, d);
    follow(2, "on sub");
    wr(OFS_CLK_SEL, 8'h01);
    poll(OFS_CLK_SEL, SEL_CPU_STAT_BIT, 1'b0, d);
    follow(1, "back on main");
    wr(OFS_OSC_MODE, 8'h41);
    wr(OFS_SETTLE_SEL, 8'hfa);
    rd(OFS_SETTLE_SEL, d);
    chk("settle sel", 8'h02, d);
    wr(OFS_OSC_RUN, 8'h43);
    chk("crystal", 8'h05, {5'h0, crystal_amp_en, ext_clock_in_en, high_freq_gain});
    poll(OFS_SETTLE_STAT, 5, 1'b1, d);
    chk("settle stat", 8'he0, d);
    wr(OFS_CLK_SEL, 8'h11);
    poll(OFS_CLK_SEL, SEL_MAIN_STAT_BIT, 1'b1, d);
    follow(3, "on crystal");
    wr(OFS_CLK_SEL, 8'h01);
    poll(OFS_CLK_SEL, SEL_MAIN_STAT_BIT, 1'b0, d);
    follow(1, "off crystal");
    wr(OFS_OSC_RUN, 8'hc3);
    rd(OFS_SETTLE_STAT, d);
    chk("halted", 8'h00, {crystal_amp_en, d[6:0]});
    wr(OFS_OSC_MODE, 8'hc0);
    ext_on <= 1'b1;
    repeat (4) @(posedge clk);
    wr(OFS_OSC_RUN, 8'h43);
    chk("ext", 8'h02, {5'h0, crystal_amp_en, ext_clock_in_en, high_freq_gain});
    wr(OFS_CLK_SEL, 8'h11);
    poll(OFS_CLK_SEL, SEL_MAIN_STAT_BIT, 1'b1, d);
    follow(3, "on ext");
    wr(OFS_OSC_RUN, 8'h42);
    repeat (6500) @(posedge clk);
    wr(OFS_CLK_SEL, 8'h00);
    poll(OFS_CLK_SEL, SEL_MAIN_STAT_BIT, 1'b0, d);
    chk("back on high", 8'h00, d);
    follow(0, "high again");
    wr(OFS_OSC_RUN, 8'hc0);
    chk("old off", 8'h04, {5'h0, high_speed_osc_run, mid_speed_osc_run, ext_clock_in_en});
    report_and_stop();
  end
endmodule

`default_nettype wire
